// [include/sfe_defines.svh]
`ifndef SFE_DEFINES_SVH
`define SFE_DEFINES_SVH

// Register byte offsets inside the socket register window.
`define SFE_OFF_MASK     8'h04
`define SFE_OFF_PRES     8'h08
`define SFE_OFF_FORCE    8'h0C

// Field positions in the live-state, force and mask words.
`define SFE_B_CAPS_HI    31
`define SFE_B_CAPS_LO    28
`define SFE_B_VIDEO      27
`define SFE_B_REINT      14
`define SFE_B_VOLT_HI    13
`define SFE_B_VOLT_LO    10
`define SFE_B_BAD        9
`define SFE_B_LOSS       8
`define SFE_B_UNREC      7
`define SFE_B_IRQ        6
`define SFE_B_WIDE       5
`define SFE_B_NARROW     4
`define SFE_B_PWR        3
`define SFE_B_DET_B      2
`define SFE_B_DET_A      1
`define SFE_B_STS        0
`define SFE_B_EVT_HI     3
`define SFE_B_MASK_HI    2
`define SFE_B_MASK_LO    1
`define SFE_B_RSV_HI     26
`define SFE_B_RSV_LO     14

// Byte lanes that carry the force fields.
`define SFE_LN_LOW       0
`define SFE_LN_CAP       1
`define SFE_LN_VID       3

// Fixed socket supply capabilities and the mask value that passes detects.
`define SFE_SOCK_CAPS    4'h3
`define SFE_MASK_PASS    2'h3

`endif

// [include/sfe_pkg.sv]
package sfe_pkg;

   // Card-interface pin levels, as they arrive from the socket.
   typedef struct packed {
      logic irq;
      logic det_b;
      logic det_a;
      logic sts;
   } sfe_pins_t;

   // Result of one card interrogation, valid with its done pulse.
   typedef struct packed {
      logic       video;
      logic [3:0] volt;
      logic       wide;
      logic       narrow;
      logic       unrec;
   } sfe_probe_t;

   // Whole state of the register bank.
   typedef struct packed {
      sfe_pins_t   s1;
      sfe_pins_t   s2;
      sfe_pins_t   s3;
      logic        irq_lvl;
      logic        sts_lvl;
      logic [1:0]  det;
      logic        video;
      logic [3:0]  volt;
      logic        bad_req;
      logic        loss;
      logic        unrec;
      logic        wide;
      logic        narrow;
      logic        powered;
      logic [1:0]  det_mask;
      logic        pwr_dis;
      logic        reint;
      logic        evt_wr;
      logic [3:0]  evt_data;
      logic        det_irq;
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
   } sfe_state_t;

endpackage : sfe_pkg

// [rtl/sfe_socket_regs.sv]
// Local design decision: the APB slave port.
`timescale 1ns/1ps
`include "sfe_defines.svh"

// Functional notes
// - Loss flag, bit 8, sets when a removal may have lost data.
// - Unrecognized-card flag, bit 7, follows interrogation until a valid card.
// - Bit 6 returns the live card interrupt/ready level.
// - Bit 5, wide card, changes only when an interrogation completes or force bit 5 is written.
// - Bit 4, narrow card, changes only when an interrogation completes or force bit 4 is written.
// - Bit 3 shows socket power state, zero after reset.
// - Bits 2 and 1 mirror card detects, frozen during interrogation.
// - Bit 0 mirrors the live card status-change level.
// - Reserved force bits read as zero.
// - Force bit 14 starts re-interrogation and re-enables power control.
// - Force bits 13..10 write voltage caps; any one set disables power.
// - Force bit 27 writes the video support bit.
// - Force bit 9 writes the bad supply request flag.
// - Force bits 8, 7, 5, 4 write loss, unrecognized, wide, narrow.
// - Force bit 3 writes the power event; power state stays as is.
// - Force bits 2, 1 write detect events; live detects stay as is.
// - Force bit 0 writes the status event; live level stays as is.
// - Force at 0Ch, live state at 08h, mask at 04h; 00h is unmapped.
// - Detect changes raise a status-change request only with mask 11.
module sfe_socket_regs
   import sfe_pkg::*;
(
   input  wire logic        REF_CLK,        // 40 MHz system clock.
   input  wire logic        ARST_N,         // Asynchronous reset, low.
   input  wire logic        PSEL,           // APB select.
   input  wire logic        PENABLE,        // APB access phase.
   input  wire logic        PWRITE,         // APB direction, high writes.
   input  wire logic [7:0]  PADDR,          // APB byte address.
   input  wire logic [31:0] PWDATA,         // APB write data.
   input  wire logic [3:0]  PSTRB,          // APB byte lane strobes.
   output      logic [31:0] PRDATA,         // APB read data.
   output      logic        PREADY,         // APB ready.
   output      logic        PSLVERR,        // APB error, unmapped address.
   input  wire sfe_pins_t   CARD_PINS,      // Raw socket pin levels.
   input  wire logic        SOCKET_PWR_ON,  // Power logic reports socket up.
   input  wire logic        LOSS_EVT,       // Removal lost data, pulse.
   input  wire logic        BAD_REQ_EVT,    // Invalid supply request, pulse.
   input  wire logic        INTERROG_BUSY,  // Interrogation in progress.
   input  wire logic        INTERROG_DONE,  // Interrogation result valid.
   input  wire sfe_probe_t  PROBE,          // Interrogation result.
   output      logic        REINTERROGATE,  // Start interrogation, pulse.
   output      logic        PWR_CTL_DIS,    // Socket power control disabled.
   output      logic        EVT_WR,         // Event register write, pulse.
   output      logic [3:0]  EVT_WR_DATA,    // Power, detect b/a, status.
   output      logic        DET_CHG_IRQ     // Detect change request, pulse.
);

   sfe_state_t  st_r;
   sfe_state_t  st_nxt;
   logic        setup;
   logic        wr_acc;
   logic [31:0] pres_word;

   // Live-state word as software sees it.
   // Reserved bits stay zero because the word starts cleared.
   always_comb begin
      pres_word = 32'h0000_0000;
      pres_word[`SFE_B_CAPS_HI:`SFE_B_CAPS_LO] = `SFE_SOCK_CAPS;
      pres_word[`SFE_B_VIDEO] = st_r.video;
      pres_word[`SFE_B_VOLT_HI:`SFE_B_VOLT_LO] = st_r.volt;
      pres_word[`SFE_B_BAD] = st_r.bad_req;
      pres_word[`SFE_B_LOSS] = st_r.loss;
      pres_word[`SFE_B_UNREC] = st_r.unrec;
      pres_word[`SFE_B_IRQ] = st_r.irq_lvl;
      pres_word[`SFE_B_WIDE] = st_r.wide;
      pres_word[`SFE_B_NARROW] = st_r.narrow;
      pres_word[`SFE_B_PWR] = st_r.powered;
      pres_word[`SFE_B_DET_B] = st_r.det[1];
      pres_word[`SFE_B_DET_A] = st_r.det[0];
      pres_word[`SFE_B_STS] = st_r.sts_lvl;
   end

   // Setup and completing-write strobes for the next-state logic.
   // A write is taken only where the master sees ready, at that edge.
   assign setup  = PSEL & ~PENABLE;
   assign wr_acc = PSEL & PENABLE & st_r.pready & PWRITE & ~st_r.pslverr;

   // Next state: pin filters, interrogation results, bus access, events.
   always_comb begin
      st_nxt = st_r;
      st_nxt.reint = 1'b0;
      st_nxt.evt_wr = 1'b0;
      st_nxt.det_irq = 1'b0;
      st_nxt.pready = 1'b0;
      st_nxt.pslverr = 1'b0;
      st_nxt.prdata = 32'h0000_0000;

      // Three-stage pin sampling; a level counts once stages two and three
      // agree, which also rejects a single-cycle glitch.
      // Only stage two reads stage one, so a metastable value stays contained.
      st_nxt.s1 = CARD_PINS;
      st_nxt.s2 = st_r.s1;
      st_nxt.s3 = st_r.s2;
      if (st_r.s2.irq == st_r.s3.irq) begin
         st_nxt.irq_lvl = st_r.s3.irq;
      end
      if (st_r.s2.sts == st_r.s3.sts) begin
         st_nxt.sts_lvl = st_r.s3.sts;
      end
      // The interrogation drives the detect pins itself, so they are held.
      if (!INTERROG_BUSY) begin
         if (st_r.s2.det_b == st_r.s3.det_b) begin
            st_nxt.det[1] = st_r.s3.det_b;
         end
         if (st_r.s2.det_a == st_r.s3.det_a) begin
            st_nxt.det[0] = st_r.s3.det_a;
         end
      end
      if (st_nxt.det != st_r.det && st_r.det_mask == `SFE_MASK_PASS) begin
         st_nxt.det_irq = 1'b1;
      end
      st_nxt.powered = SOCKET_PWR_ON;

      // Outside force writes, card type and capabilities change only with a finished interrogation.
      // It also clears the loss and supply flags; events below still win.
      if (INTERROG_DONE) begin
         st_nxt.video = PROBE.video;
         st_nxt.volt = PROBE.volt;
         st_nxt.wide = PROBE.wide;
         st_nxt.narrow = PROBE.narrow;
         st_nxt.unrec = PROBE.unrec;
         st_nxt.loss = 1'b0;
         st_nxt.bad_req = 1'b0;
      end

      // Zero-wait APB: answer is prepared in the setup cycle.
      if (setup) begin
         st_nxt.pready = 1'b1;
         case (PADDR)
            `SFE_OFF_MASK: begin
               st_nxt.prdata[`SFE_B_MASK_HI:`SFE_B_MASK_LO] = st_r.det_mask;
            end
            `SFE_OFF_PRES: begin
               st_nxt.prdata = pres_word;
            end
            `SFE_OFF_FORCE: begin
               st_nxt.prdata = 32'h0000_0000;
            end
            default: begin
               st_nxt.pslverr = 1'b1;
            end
         endcase
      end

      // Register writes take effect at the completing edge only.
      if (wr_acc && PADDR == `SFE_OFF_MASK && PSTRB[`SFE_LN_LOW]) begin
         st_nxt.det_mask = PWDATA[`SFE_B_MASK_HI:`SFE_B_MASK_LO];
      end
      if (wr_acc && PADDR == `SFE_OFF_FORCE) begin
         if (PSTRB[`SFE_LN_VID]) begin
            st_nxt.video = PWDATA[`SFE_B_VIDEO];
         end
         if (PSTRB[`SFE_LN_CAP]) begin
            if (PWDATA[`SFE_B_REINT]) begin
               st_nxt.reint = 1'b1;
               st_nxt.pwr_dis = 1'b0;
            end
            st_nxt.volt = PWDATA[`SFE_B_VOLT_HI:`SFE_B_VOLT_LO];
            // A disabling bit in the same write outranks the re-enable.
            if (|PWDATA[`SFE_B_VOLT_HI:`SFE_B_VOLT_LO]) begin
               st_nxt.pwr_dis = 1'b1;
            end
            st_nxt.bad_req = PWDATA[`SFE_B_BAD];
            st_nxt.loss = PWDATA[`SFE_B_LOSS];
         end
         if (PSTRB[`SFE_LN_LOW]) begin
            st_nxt.unrec = PWDATA[`SFE_B_UNREC];
            st_nxt.wide = PWDATA[`SFE_B_WIDE];
            st_nxt.narrow = PWDATA[`SFE_B_NARROW];
            // Event bits go to the event register; live bits are untouched.
            st_nxt.evt_wr = 1'b1;
            st_nxt.evt_data = PWDATA[`SFE_B_EVT_HI:`SFE_B_STS];
         end
      end

      // Hardware events outrank a clearing write in the same cycle.
      // Software thus cannot lose a hardware event by clearing it at once.
      if (LOSS_EVT) begin
         st_nxt.loss = 1'b1;
      end
      if (BAD_REQ_EVT) begin
         st_nxt.bad_req = 1'b1;
      end
   end

   // State register. Reset clears everything, so detects read zero
   // until the pins have been sampled.
   always_ff @(posedge REF_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Every output is a state bit, so none has a combinational path.
   assign PRDATA = st_r.prdata;
   assign PREADY = st_r.pready;
   assign PSLVERR = st_r.pslverr;
   assign REINTERROGATE = st_r.reint;
   assign PWR_CTL_DIS = st_r.pwr_dis;
   assign EVT_WR = st_r.evt_wr;
   assign EVT_WR_DATA = st_r.evt_data;
   assign DET_CHG_IRQ = st_r.det_irq;

   // Checks share the system clock and are quiet during reset.
   default clocking cb @(posedge REF_CLK);
   endclocking
   default disable iff (!ARST_N);

   // Bus answers in the first access cycle.
   bus_ready_a: assert property (PSEL && !PENABLE |=> PREADY)
      else $error("ready missing after setup");

   // Force register always reads zero.
   force_zero_a: assert property (
      PSEL && !PENABLE && !PWRITE && PADDR == `SFE_OFF_FORCE
      |=> PRDATA == 32'h0000_0000 && !PSLVERR)
      else $error("force register read not zero");

   // Reinterrogation is a single pulse with power control enabled.
   reint_pulse_a: assert property (
      wr_acc && PADDR == `SFE_OFF_FORCE && PSTRB[`SFE_LN_CAP]
      && PWDATA[`SFE_B_REINT]
      && PWDATA[`SFE_B_VOLT_HI:`SFE_B_VOLT_LO] == 4'h0
      |=> REINTERROGATE && !PWR_CTL_DIS ##1 !REINTERROGATE)
      else $error("reinterrogate pulse wrong");

   // Forcing a voltage bit disables power control.
   volt_dis_a: assert property (
      wr_acc && PADDR == `SFE_OFF_FORCE && PSTRB[`SFE_LN_CAP]
      && |PWDATA[`SFE_B_VOLT_HI:`SFE_B_VOLT_LO]
      |=> PWR_CTL_DIS
      && st_r.volt == $past(PWDATA[`SFE_B_VOLT_HI:`SFE_B_VOLT_LO]))
      else $error("power control not disabled");

   // Event bits pass to the event register.
   evt_force_a: assert property (
      wr_acc && PADDR == `SFE_OFF_FORCE && PSTRB[`SFE_LN_LOW]
      |=> EVT_WR
      && EVT_WR_DATA == $past(PWDATA[`SFE_B_EVT_HI:`SFE_B_STS])
      && st_r.powered == $past(SOCKET_PWR_ON))
      else $error("event write not forwarded");

   // Loss flag survives any write in its set cycle.
   loss_set_a: assert property (LOSS_EVT |=> st_r.loss)
      else $error("loss flag not set");

   // Power state follows the power logic.
   pwr_track_a: assert property (
      1'b1 |=> st_r.powered == $past(SOCKET_PWR_ON))
      else $error("power state not tracked");

   // Detects hold still while the card is interrogated.
   det_freeze_a: assert property (
      INTERROG_BUSY |=> $stable(st_r.det))
      else $error("detect changed during interrogation");

   // Stable irq pin reaches the live bit.
   irq_level_a: assert property (
      $stable(CARD_PINS.irq) [*4] |=> st_r.irq_lvl == $past(CARD_PINS.irq))
      else $error("irq level not mirrored");

   // Detect change request only with the mask fully open.
   det_mask_a: assert property (
      DET_CHG_IRQ |-> $past(st_r.det_mask) == `SFE_MASK_PASS
      && st_r.det != $past(st_r.det))
      else $error("detect request while masked");

   // Card type follows the interrogation result.
   probe_load_a: assert property (
      INTERROG_DONE && !(wr_acc && PADDR == `SFE_OFF_FORCE)
      |=> st_r.wide == $past(PROBE.wide)
      && st_r.narrow == $past(PROBE.narrow))
      else $error("card type not loaded");

   // Card type holds between interrogations unless software forces it.
   type_hold_a: assert property (
      !INTERROG_DONE
      && !(wr_acc && PADDR == `SFE_OFF_FORCE && PSTRB[`SFE_LN_LOW])
      |=> $stable(st_r.wide) && $stable(st_r.narrow)
      && $stable(st_r.unrec))
      else $error("card type changed without cause");

   // Stable status-change pin reaches the live bit.
   sts_level_a: assert property (
      $stable(CARD_PINS.sts) [*4] |=> st_r.sts_lvl == $past(CARD_PINS.sts))
      else $error("status level not mirrored");

   // Stable detect pins reach the live bits outside an interrogation.
   det_level_a: assert property (
      ($stable(CARD_PINS.det_b) && $stable(CARD_PINS.det_a)
      && !INTERROG_BUSY) [*4]
      |=> st_r.det == {$past(CARD_PINS.det_b), $past(CARD_PINS.det_a)})
      else $error("detect levels not mirrored");

   // An unmapped address is refused with an error and zero data.
   unmapped_err_a: assert property (
      PSEL && !PENABLE && PADDR != `SFE_OFF_MASK
      && PADDR != `SFE_OFF_PRES && PADDR != `SFE_OFF_FORCE
      |=> PREADY && PSLVERR && PRDATA == 32'h0000_0000)
      else $error("unmapped access not refused");

   // The live-state word carries the socket supplies and zero reserved bits.
   live_fixed_a: assert property (
      PSEL && !PENABLE && !PWRITE && PADDR == `SFE_OFF_PRES
      |=> !PSLVERR
      && PRDATA[`SFE_B_CAPS_HI:`SFE_B_CAPS_LO] == `SFE_SOCK_CAPS
      && PRDATA[`SFE_B_RSV_HI:`SFE_B_RSV_LO] == 13'h0000)
      else $error("live state fixed fields wrong");

   // Ready lasts one cycle, since it is raised only after a setup cycle.
   ready_once_a: assert property (PREADY |=> !PREADY)
      else $error("ready held too long");

   // Read data and error stand only with ready.
   bus_idle_a: assert property (
      !PREADY |-> PRDATA == 32'h0000_0000 && !PSLVERR)
      else $error("read data outside answer");

   // Hardware request for an invalid supply sets its flag.
   bad_set_a: assert property (BAD_REQ_EVT |=> st_r.bad_req)
      else $error("bad supply flag not set");

   // No event write without a lane-0 force write.
   evt_quiet_a: assert property (
      !(wr_acc && PADDR == `SFE_OFF_FORCE && PSTRB[`SFE_LN_LOW])
      |=> !EVT_WR)
      else $error("spurious event write");

   // No reinterrogation without a force write of bit 14.
   reint_quiet_a: assert property (
      !(wr_acc && PADDR == `SFE_OFF_FORCE && PSTRB[`SFE_LN_CAP]
      && PWDATA[`SFE_B_REINT])
      |=> !REINTERROGATE)
      else $error("spurious reinterrogation");

   // Power control changes only through a force write.
   pwr_dis_cause_a: assert property (
      $changed(PWR_CTL_DIS)
      |-> $past(wr_acc) && $past(PADDR) == `SFE_OFF_FORCE)
      else $error("power control changed without cause");

   // Forced video bit lands in the live word.
   video_force_a: assert property (
      wr_acc && PADDR == `SFE_OFF_FORCE && PSTRB[`SFE_LN_VID]
      |=> st_r.video == $past(PWDATA[`SFE_B_VIDEO]))
      else $error("video support not forced");

   // Forced loss and supply flags land unless hardware sets them.
   flag_force_a: assert property (
      wr_acc && PADDR == `SFE_OFF_FORCE && PSTRB[`SFE_LN_CAP]
      && !LOSS_EVT && !BAD_REQ_EVT
      |=> st_r.loss == $past(PWDATA[`SFE_B_LOSS])
      && st_r.bad_req == $past(PWDATA[`SFE_B_BAD]))
      else $error("loss or supply flag not forced");

   // Forced card-type bits land in the live word.
   type_force_a: assert property (
      wr_acc && PADDR == `SFE_OFF_FORCE && PSTRB[`SFE_LN_LOW]
      |=> st_r.unrec == $past(PWDATA[`SFE_B_UNREC])
      && st_r.wide == $past(PWDATA[`SFE_B_WIDE])
      && st_r.narrow == $past(PWDATA[`SFE_B_NARROW]))
      else $error("card type not forced");

   // A closed mask keeps detect changes from raising a request.
   mask_quiet_a: assert property (
      st_r.det_mask != `SFE_MASK_PASS |=> !DET_CHG_IRQ)
      else $error("detect request through closed mask");

endmodule : sfe_socket_regs

// [testbench/sfe_card_model.sv]
`timescale 1ns/1ps

// Card in the socket: shows pin levels and answers an interrogation.
module sfe_card_model
   import sfe_pkg::*;
#(
   parameter int BUSY_CYC = 12
)
(
   input  wire logic       clk,       // System clock.
   input  wire logic       rst_n,     // Asynchronous reset, low.
   input  wire logic       start,     // Interrogation request pulse.
   input  wire sfe_pins_t  pins_set,  // Levels the card presents.
   input  wire sfe_probe_t probe_set, // Identity the card reports.
   output      sfe_pins_t  pins,      // Socket pin levels.
   output      logic       busy,      // Interrogation running.
   output      logic       done,      // Result valid, one cycle.
   output      sfe_probe_t probe      // Interrogation result.
);
   int cnt_r;

   // Pins are live levels; the result is inverted outside its done cycle
   // so that a bank which loads it early reads garbage.
   assign pins  = pins_set;
   assign probe = done ? probe_set : ~probe_set;

   // The interrogation takes a fixed number of cycles after the request.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r <= 0;
         busy  <= 1'b0;
         done  <= 1'b0;
      end else begin
         done <= 1'b0;
         if (start) begin
            cnt_r <= BUSY_CYC;
            busy  <= 1'b1;
         end else if (cnt_r == 1) begin
            cnt_r <= 0;
            busy  <= 1'b0;
            done  <= 1'b1;
         end else if (cnt_r > 1) begin
            cnt_r <= cnt_r - 1;
         end
      end
   end
endmodule : sfe_card_model

// [testbench/testbench.sv]
`timescale 1ns/1ps

// Drives the register bank over APB and the card model, checks read words.
module testbench;
   import sfe_pkg::*;

   logic        ref_clk, arst_n, psel, penable, pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, r;
   logic [3:0]  pstrb, evt_data;
   logic        pready, pslverr, pwr_on, loss, bad, e;
   logic        reint, pwr_dis, evt_wr, det_irq, busy, done;
   sfe_pins_t   pins_set, pins;
   sfe_probe_t  probe_set, probe;
   int          fails = 0;
   int          checks = 0;
   int          irq_cnt = 0;
   int          n0;

   sfe_socket_regs i_sfe_socket_regs (
      .REF_CLK(ref_clk), .ARST_N(arst_n), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb),
      .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .CARD_PINS(pins), .SOCKET_PWR_ON(pwr_on), .LOSS_EVT(loss),
      .BAD_REQ_EVT(bad), .INTERROG_BUSY(busy), .INTERROG_DONE(done),
      .PROBE(probe), .REINTERROGATE(reint), .PWR_CTL_DIS(pwr_dis),
      .EVT_WR(evt_wr), .EVT_WR_DATA(evt_data), .DET_CHG_IRQ(det_irq));

   sfe_card_model i_sfe_card_model (
      .clk(ref_clk), .rst_n(arst_n), .start(reint), .pins_set(pins_set),
      .probe_set(probe_set), .pins(pins), .busy(busy), .done(done),
      .probe(probe));

   // A 40 MHz clock.
   initial begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end

   // Counts one-cycle detect requests, so a stuck level shows as many.
   always @(posedge ref_clk) begin
      if (det_irq === 1'b1) irq_cnt++;
   end

   task automatic tally_and_finish;
      if (fails == 0 && checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : tally_and_finish

   task automatic chk(input string nm, input logic [31:0] got, x);
      checks++;
      if (got !== x) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", nm, x, got);
      end
   endtask : chk

   // One APB transfer; the request is held until ready is sampled high.
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, input logic [3:0] s,
                      output logic [31:0] rd_v, output logic err);
      int n;
      @(posedge ref_clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      pstrb   <= s;
      @(posedge ref_clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) begin
         fails++;
         tally_and_finish();
      end
      rd_v = prdata;
      err  = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // Write, then step past the edge so registered pulses can be looked at.
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s);
      apb(1'b1, a, d, s, r, e);
      #1;
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] x,
                     input string nm);
      apb(1'b0, a, 32'h0000_0000, 4'h0, r, e);
      chk(nm, r, x);
   endtask : rd

   task automatic wait_idle;
      int n;
      n = 0;
      while (busy !== 1'b0 && n < 100) begin
         @(posedge ref_clk);
         n++;
      end
      if (n >= 100) begin
         fails++;
         tally_and_finish();
      end
   endtask : wait_idle

   // Main sequence; expected words are hex constants worked out from the map.
   initial begin
      {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
      {pwr_on, loss, bad} = 3'h0;
      pins_set  = sfe_pins_t'(4'hE);
      probe_set = sfe_probe_t'(8'h00);
      arst_n    = 1'b0;
      repeat (20) @(posedge ref_clk);
      arst_n <= 1'b1;
      repeat (6) @(posedge ref_clk);
      rd(8'h08, 32'h3000_0046, "live reset");
      rd(8'h0C, 32'h0000_0000, "force read");
      rd(8'h04, 32'h0000_0000, "mask reset");
      apb(1'b0, 8'h00, 32'h0000_0000, 4'h0, r, e);
      chk("unmapped err", {31'h0, e}, 32'h0000_0001);
      wr(8'h0C, 32'h0800_03B0, 4'hF);
      chk("evt wr", {31'h0, evt_wr}, 32'h0000_0001);
      chk("evt data", {28'h0, evt_data}, 32'h0000_0000);
      rd(8'h08, 32'h3800_03F6, "forced flags");
      wr(8'h0C, 32'h0000_3C00, 4'h2);
      chk("pwr dis", {31'h0, pwr_dis}, 32'h0000_0001);
      chk("no evt wr", {31'h0, evt_wr}, 32'h0000_0000);
      rd(8'h08, 32'h3800_3CF6, "volt caps");
      wr(8'h0C, 32'h0000_000F, 4'h1);
      chk("evt wr f", {31'h0, evt_wr}, 32'h0000_0001);
      chk("evt data f", {28'h0, evt_data}, 32'h0000_000F);
      rd(8'h08, 32'h3800_3C46, "live kept");
      probe_set <= sfe_probe_t'(8'h1C);
      wr(8'h0C, 32'h0000_4000, 4'h2);
      chk("reint", {31'h0, reint}, 32'h0000_0001);
      chk("pwr on ctl", {31'h0, pwr_dis}, 32'h0000_0000);
      @(posedge ref_clk);
      pins_set.det_b <= 1'b0;
      repeat (4) @(posedge ref_clk);
      rd(8'h08, 32'h3800_0046, "frozen detect");
      wait_idle();
      repeat (6) @(posedge ref_clk);
      rd(8'h08, 32'h3000_0C62, "probe result");
      @(posedge ref_clk);
      pins_set.irq <= 1'b0;
      pins_set.sts <= 1'b1;
      {pwr_on, loss, bad} <= 3'h7;
      @(posedge ref_clk);
      {loss, bad} <= 2'h0;
      repeat (6) @(posedge ref_clk);
      rd(8'h08, 32'h3000_0F2B, "live events");
      n0 = irq_cnt;
      @(posedge ref_clk);
      pins_set.det_a <= 1'b0;
      repeat (8) @(posedge ref_clk);
      chk("masked irq", 32'(irq_cnt - n0), 32'h0000_0000);
      wr(8'h04, 32'h0000_0006, 4'hF);
      rd(8'h04, 32'h0000_0006, "mask rw");
      @(posedge ref_clk);
      pins_set.det_a <= 1'b1;
      repeat (8) @(posedge ref_clk);
      chk("det irq", 32'(irq_cnt - n0), 32'h0000_0001);
      rd(8'h0C, 32'h0000_0000, "force zero");
      tally_and_finish();
   end
endmodule : testbench
